// file: rtl/fsg_guard.sv
// Flash self-write guard with undervolt reset gating and register port
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps

// Notes on behaviour
// RQ1: Bit 7 of the self-write control register reads 1 while byte write or page erase is enabled.
// RQ2: Hardware sets the time-out flag, bit 6 of that register, when the write watchdog expires.
// RQ3: Hardware clears the time-out flag whenever self-write returns to disabled.
// RQ4: Watchdog select code 00 disables it; 01, 10, 11 wait 0.8, 3.2, 6.4 ms then time out.
// RQ5: Bit 3 of the first auxiliary register disables the undervolt reset; it resets to 0.
// RQ6: A three-bit config field picks one of eight rising undervolt reset levels.
// RQ7: A four-bit detect-select field picks one of sixteen detect levels on its own.
// RQ8: Reset enabled: level reset in fast and slow, and in idle, halt, stop without power-save.
// RQ9: Reset disabled: power-on reset only in fast, slow and idle, and none in halt and stop.
// RQ10: Codes 4A/4C enable a low/high page byte write, BA/BC a page erase, others disable.
// RQ11: Writing 65h to the command register arms self-write and any other value disarms it.
// RQ12: Power-save set disables the undervolt reset in idle, halt and stop.
// RQ13: While the undervolt reset is active, a comparator report below threshold raises reset.
module fsg_guard
    import fsg_pkg::*;
#(
    parameter int P1_CYC = WD_P1_CYC,
    parameter int P2_CYC = WD_P2_CYC,
    parameter int P3_CYC = WD_P3_CYC
) (
    // Clock and reset
    input  wire logic               CLK_I,
    input  wire logic               NRST_I,
    // Register port
    input  wire logic [7:0]         ADDR_I,
    input  wire logic [7:0]         WDATA_I,
    input  wire logic               WR_I,
    input  wire logic               RD_I,
    output logic      [7:0]         RDATA_O,
    // Configuration and power state
    input  wire logic [7:0]         CONFIG_WORD_HIGH_I,
    input  wire logic [2:0]         POWER_MODE_I,
    // Analog comparators
    input  wire logic               BELOW_LEVEL_I,
    input  wire logic               BELOW_POR_I,
    input  wire logic               BELOW_DETECT_I,
    // Flash controller side
    output logic                    SELFWRITE_ARMED_O,
    output logic                    WRITE_LOW_O,
    output logic                    WRITE_HIGH_O,
    output logic                    ERASE_LOW_O,
    output logic                    ERASE_HIGH_O,
    output logic                    WRITE_ABORT_O,
    // Undervolt control
    output logic [LEVEL_W-1:0]      UNDERVOLT_RESET_LEVEL_O,
    output logic [DETSEL_W-1:0]     UNDERVOLT_DETECT_SEL_O,
    output logic [1:0]              UVR_SOURCE_O,
    output logic                    RESET_REQ_O,
    output logic                    IRQ_O
);
    // ********************************************************
    // Register state
    // ********************************************************
    logic [7:0]          selfwrite_code;
    logic                armed;
    logic                timeout_flag;
    logic [7:0]          aux_control_two;
    logic [7:0]          aux_control_one;
    logic [DETSEL_W-1:0] detect_sel;
    logic [IRQ_W-1:0]    irq_status;
    logic [IRQ_W-1:0]    irq_mask;
    logic                selfwrite_enable;
    logic                wr_sw;
    logic [IRQ_W-1:0]    irq_event;
    fsg_uvr_src_t        next_src;
    fsg_wd_if            wd_bus ();

    // Synchronised comparator levels
    logic [2:0]          cmp_meta;
    logic [2:0]          cmp_sync;
    logic                below_level;
    logic                below_por;
    logic                below_detect;
    logic                detect_d;

    assign wr_sw = WR_I && (ADDR_I == REG_SELFWRITE);

    // Enabled only for the four documented codes with the command armed
    always_comb begin
        case (selfwrite_code)
            CMD_WRITE_LOW, CMD_WRITE_HIGH,
            CMD_ERASE_LOW, CMD_ERASE_HIGH: selfwrite_enable = armed; // [RQ10]
            default:                       selfwrite_enable = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            selfwrite_code <= REG_RESET_VAL;
        end else if (wr_sw) begin
            selfwrite_code <= WDATA_I; // [RQ10]
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            armed <= 1'b0;
        end else if (WR_I && ADDR_I == REG_SW_COMMAND) begin
            armed <= (WDATA_I == CMD_ARM); // [RQ11]
        end
    end

    // ********************************************************
    // Write watchdog
    // ********************************************************
    assign wd_bus.run = selfwrite_enable;
    assign wd_bus.sel = aux_control_two[WDSEL_LO+1:WDSEL_LO]; // [RQ4]

    fsg_watchdog #(
        .P1_CYC (P1_CYC),
        .P2_CYC (P2_CYC),
        .P3_CYC (P3_CYC)
    ) u_watchdog (
        .CLK_I  (CLK_I),
        .NRST_I (NRST_I),
        .wd     (wd_bus.timer)
    );

    // Expiry wins over a clear in the same cycle
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            timeout_flag <= 1'b0;
        end else if (wd_bus.expire) begin
            timeout_flag <= 1'b1; // [RQ2]
        end else if (!selfwrite_enable) begin
            timeout_flag <= 1'b0; // [RQ3]
        end
    end

    // ********************************************************
    // Auxiliary and detect registers
    // ********************************************************
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            aux_control_two <= REG_RESET_VAL;
        end else if (WR_I && ADDR_I == REG_AUX_TWO) begin
            aux_control_two <= WDATA_I;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            aux_control_one <= REG_RESET_VAL; // [RQ5]
        end else if (WR_I && ADDR_I == REG_AUX_ONE) begin
            aux_control_one <= WDATA_I;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            detect_sel <= '0;
        end else if (WR_I && ADDR_I == REG_DETECT_SEL) begin
            detect_sel <= WDATA_I[DETSEL_W-1:0]; // [RQ7]
        end
    end

    // ********************************************************
    // Comparator synchronisers
    // ********************************************************
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            cmp_meta <= '0;
            cmp_sync <= '0;
        end else begin
            cmp_meta <= {BELOW_DETECT_I, BELOW_POR_I, BELOW_LEVEL_I};
            cmp_sync <= cmp_meta;
        end
    end

    assign below_level  = cmp_sync[0];
    assign below_por    = cmp_sync[1];
    assign below_detect = cmp_sync[2];

    // ********************************************************
    // Undervolt reset gating
    // ********************************************************
    always_comb begin
        next_src = FSG_UVR_OFF;
        case (POWER_MODE_I)
            MODE_FAST, MODE_SLOW: begin
                next_src = aux_control_one[UVR_DIS_BIT] ? FSG_UVR_POR : FSG_UVR_LEVEL;
            end
            MODE_IDLE: begin
                if (aux_control_one[UVR_DIS_BIT] || aux_control_two[PWRSAVE_BIT]) begin
                    next_src = FSG_UVR_POR; // [RQ8] [RQ9] [RQ12]
                end else begin
                    next_src = FSG_UVR_LEVEL; // [RQ8]
                end
            end
            MODE_HALT, MODE_STOP: begin
                if (aux_control_one[UVR_DIS_BIT] || aux_control_two[PWRSAVE_BIT]) begin
                    next_src = FSG_UVR_OFF; // [RQ9] [RQ12]
                end else begin
                    next_src = FSG_UVR_LEVEL; // [RQ8]
                end
            end
            default: next_src = FSG_UVR_LEVEL;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            RESET_REQ_O <= 1'b0;
        end else begin
            case (next_src)
                FSG_UVR_LEVEL: RESET_REQ_O <= below_level; // [RQ13]
                FSG_UVR_POR:   RESET_REQ_O <= below_por;
                default:       RESET_REQ_O <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            UVR_SOURCE_O <= 2'h0;
        end else begin
            UVR_SOURCE_O <= 2'(next_src);
        end
    end

    // Level select passes straight to the analog trim
    assign UNDERVOLT_RESET_LEVEL_O =
        CONFIG_WORD_HIGH_I[CFG_LEVEL_LO+LEVEL_W-1:CFG_LEVEL_LO]; // [RQ6]
    assign UNDERVOLT_DETECT_SEL_O = detect_sel; // [RQ7]

    // ********************************************************
    // Flash controller strobes
    // ********************************************************
    assign SELFWRITE_ARMED_O = armed;
    assign WRITE_LOW_O  = selfwrite_enable && (selfwrite_code == CMD_WRITE_LOW);
    assign WRITE_HIGH_O = selfwrite_enable && (selfwrite_code == CMD_WRITE_HIGH);
    assign ERASE_LOW_O  = selfwrite_enable && (selfwrite_code == CMD_ERASE_LOW);
    assign ERASE_HIGH_O = selfwrite_enable && (selfwrite_code == CMD_ERASE_HIGH);
    assign WRITE_ABORT_O = wd_bus.expire; // [RQ4]

    // ********************************************************
    // Interrupts
    // ********************************************************
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            detect_d <= 1'b0;
        end else begin
            detect_d <= below_detect;
        end
    end

    assign irq_event = {below_detect && !detect_d, RESET_REQ_O, wd_bus.expire};

    // Set wins over write-one-to-clear
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            irq_status <= '0;
        end else if (WR_I && ADDR_I == REG_IRQ_STATUS) begin
            irq_status <= (irq_status & ~WDATA_I[IRQ_W-1:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            irq_mask <= '0;
        end else if (WR_I && ADDR_I == REG_IRQ_MASK) begin
            irq_mask <= WDATA_I[IRQ_W-1:0];
        end
    end

    assign IRQ_O = |(irq_status & irq_mask);

    // ********************************************************
    // Read port
    // ********************************************************
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            RDATA_O <= REG_RESET_VAL;
        end else if (RD_I) begin
            case (ADDR_I)
                REG_SELFWRITE:  RDATA_O <= {selfwrite_enable, timeout_flag, 6'h00}; // [RQ1]
                REG_SW_COMMAND: RDATA_O <= {7'h00, armed};
                REG_AUX_TWO:    RDATA_O <= aux_control_two;
                REG_AUX_ONE:    RDATA_O <= aux_control_one;
                REG_DETECT_SEL: RDATA_O <= {1'b0, below_detect, 2'h0, detect_sel};
                REG_IRQ_STATUS: RDATA_O <= {5'h00, irq_status};
                REG_IRQ_MASK:   RDATA_O <= {5'h00, irq_mask};
                default:        RDATA_O <= REG_RESET_VAL;
            endcase
        end else begin
            RDATA_O <= REG_RESET_VAL;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    chk_timeout_set: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ2]
        wd_bus.expire |=> timeout_flag)
        else $error("time-out flag not set after expiry");

    chk_timeout_clear: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ3]
        (!selfwrite_enable && !wd_bus.expire) |=> !timeout_flag)
        else $error("time-out flag kept while disabled");

    chk_enable_read: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ1]
        (RD_I && ADDR_I == REG_SELFWRITE) |=> RDATA_O[SW_EN_BIT] == $past(selfwrite_enable))
        else $error("enable bit read mismatch");

    chk_arm_code: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ11]
        (WR_I && ADDR_I == REG_SW_COMMAND) |=> armed == ($past(WDATA_I) == CMD_ARM))
        else $error("arm state wrong after command write");

    chk_erase_low: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ10]
        (armed && wr_sw && WDATA_I == CMD_ERASE_LOW
         && !(WR_I && ADDR_I == REG_SW_COMMAND)) |=> ERASE_LOW_O && !WRITE_LOW_O)
        else $error("erase low not enabled");

    chk_halt_off: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ9]
        (POWER_MODE_I == MODE_HALT && aux_control_one[UVR_DIS_BIT]) |=> !RESET_REQ_O)
        else $error("reset raised in halt while disabled");

    chk_level_reset: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ13]
        (POWER_MODE_I == MODE_FAST && !aux_control_one[UVR_DIS_BIT])
        |=> RESET_REQ_O == $past(below_level))
        else $error("level reset does not follow comparator");

    chk_idle_saving: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ12]
        (POWER_MODE_I == MODE_IDLE && aux_control_two[PWRSAVE_BIT])
        |=> UVR_SOURCE_O == 2'(FSG_UVR_POR))
        else $error("idle with power-save not on power-on reset");

    chk_idle_level: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ8]
        (POWER_MODE_I == MODE_IDLE && !aux_control_two[PWRSAVE_BIT]
         && !aux_control_one[UVR_DIS_BIT]) |=> UVR_SOURCE_O == 2'(FSG_UVR_LEVEL))
        else $error("idle without power-save lost level reset");

    chk_wd_off: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ4]
        (wd_bus.sel == WD_OFF) |-> !wd_bus.expire)
        else $error("watchdog expired while disabled");
endmodule : fsg_guard

// file: rtl/fsg_pkg.sv
// Package: register map, field positions and timing constants of the flash self-write guard
package fsg_pkg;
    // Register offsets
    localparam logic [7:0] REG_SW_COMMAND   = 8'h97;
    localparam logic [7:0] REG_SELFWRITE    = 8'hC9;
    localparam logic [7:0] REG_DETECT_SEL   = 8'hBF;
    localparam logic [7:0] REG_AUX_TWO      = 8'hF7;
    localparam logic [7:0] REG_AUX_ONE      = 8'hF8;
    localparam logic [7:0] REG_IRQ_STATUS   = 8'hD0;
    localparam logic [7:0] REG_IRQ_MASK     = 8'hD1;
    localparam logic [7:0] REG_RESET_VAL    = 8'h00;

    // Command codes
    localparam logic [7:0] CMD_ARM          = 8'h65;
    localparam logic [7:0] CMD_WRITE_LOW    = 8'h4A;
    localparam logic [7:0] CMD_WRITE_HIGH   = 8'h4C;
    localparam logic [7:0] CMD_ERASE_LOW    = 8'hBA;
    localparam logic [7:0] CMD_ERASE_HIGH   = 8'hBC;

    // Field positions
    localparam int SW_EN_BIT       = 7;
    localparam int SW_TO_BIT       = 6;
    localparam int WDSEL_LO        = 1;
    localparam int PWRSAVE_BIT     = 5;
    localparam int UVR_DIS_BIT     = 3;
    localparam int DETSEL_W        = 4;
    localparam int LEVEL_W         = 3;
    localparam int CFG_LEVEL_LO    = 3;
    localparam int IRQ_W           = 3;
    localparam int IRQ_TIMEOUT     = 0;
    localparam int IRQ_UVRESET     = 1;
    localparam int IRQ_DETECT      = 2;

    // Watchdog periods
    localparam int CLK_MHZ         = 200;
    localparam int WD_P1_US        = 800;
    localparam int WD_P2_US        = 3200;
    localparam int WD_P3_US        = 6400;
    localparam int WD_P1_CYC       = WD_P1_US * CLK_MHZ;
    localparam int WD_P2_CYC       = WD_P2_US * CLK_MHZ;
    localparam int WD_P3_CYC       = WD_P3_US * CLK_MHZ;
    localparam int WD_CNT_W        = 21;

    // Watchdog select codes
    localparam logic [1:0] WD_OFF  = 2'h0;
    localparam logic [1:0] WD_SEL1 = 2'h1;
    localparam logic [1:0] WD_SEL2 = 2'h2;

    // Undervolt reset comparator selection
    typedef enum {FSG_POWER_FAST, FSG_POWER_SLOW, FSG_POWER_IDLE, FSG_POWER_HALT,
                  FSG_POWER_STOP} fsg_power_mode_t;
    typedef enum {FSG_UVR_OFF, FSG_UVR_POR, FSG_UVR_LEVEL} fsg_uvr_src_t;
    localparam logic [2:0] MODE_FAST = 3'h0;
    localparam logic [2:0] MODE_SLOW = 3'h1;
    localparam logic [2:0] MODE_IDLE = 3'h2;
    localparam logic [2:0] MODE_HALT = 3'h3;
    localparam logic [2:0] MODE_STOP = 3'h4;
endpackage : fsg_pkg

// file: rtl/fsg_wd_if.sv
// Interface between the guard and its write watchdog timer
`timescale 1ns/10ps
interface fsg_wd_if;
    logic       run;
    logic [1:0] sel;
    logic       expire;
    modport ctrl  (output run, output sel, input expire);
    modport timer (input run, input sel, output expire);
endinterface : fsg_wd_if

// file: rtl/fsg_watchdog.sv
// Self-write watchdog timer: one pulse when the selected period has run out
`timescale 1ns/10ps
module fsg_watchdog
    import fsg_pkg::*;
#(
    parameter int P1_CYC = WD_P1_CYC,
    parameter int P2_CYC = WD_P2_CYC,
    parameter int P3_CYC = WD_P3_CYC
) (
    // Clock and reset
    input  wire logic CLK_I,
    input  wire logic NRST_I,
    // Control
    fsg_wd_if.timer   wd
);
    logic [WD_CNT_W-1:0] count;
    logic [WD_CNT_W-1:0] limit;
    logic                fired;

    always_comb begin
        case (wd.sel)
            WD_SEL1: limit = WD_CNT_W'(P1_CYC - 1);
            WD_SEL2: limit = WD_CNT_W'(P2_CYC - 1);
            default: limit = WD_CNT_W'(P3_CYC - 1);
        endcase
    end

    // Counts only while a self-write is open; one expiry per opening
    always_ff @(posedge CLK_I) begin
        if (!NRST_I || !wd.run || wd.sel == WD_OFF) begin
            count <= '0;
            fired <= 1'b0;
        end else if (!fired) begin
            if (count == limit) begin
                fired <= 1'b1;
            end else begin
                count <= count + WD_CNT_W'(1);
            end
        end
    end

    assign wd.expire = wd.run && (wd.sel != WD_OFF) && !fired && (count == limit);
endmodule : fsg_watchdog

// file: dv/fsg_guard_tb.sv
// Self-checking testbench of the flash self-write guard
`timescale 1ns/10ps
module fsg_guard_tb
    import fsg_pkg::*;
;
    // ************************************************************
    // Stimulus, observed outputs and bookkeeping
    // ************************************************************
    logic       clk, nrst, wr, rd, b_lvl, b_por, b_det;
    logic [7:0] addr, wdata, cfg, d, code;
    logic [2:0] mode;
    logic [7:0] rdata;
    logic       armed, w_lo, w_hi, e_lo, e_hi, abort, rreq, irq, irq_a;
    logic [2:0] lvl;
    logic [3:0] dsel;
    logic [1:0] src;
    int         fails, checked, cyc, n, e, per;
    logic [7:0] codes[$];

    // Short periods keep the watchdog runs brief
    fsg_guard #(.P1_CYC(20), .P2_CYC(40), .P3_CYC(80)) i_dut (
        .CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .CONFIG_WORD_HIGH_I(cfg), .POWER_MODE_I(mode),
        .BELOW_LEVEL_I(b_lvl), .BELOW_POR_I(b_por), .BELOW_DETECT_I(b_det),
        .SELFWRITE_ARMED_O(armed), .WRITE_LOW_O(w_lo), .WRITE_HIGH_O(w_hi),
        .ERASE_LOW_O(e_lo), .ERASE_HIGH_O(e_hi), .WRITE_ABORT_O(abort),
        .UNDERVOLT_RESET_LEVEL_O(lvl), .UNDERVOLT_DETECT_SEL_O(dsel),
        .UVR_SOURCE_O(src), .RESET_REQ_O(rreq), .IRQ_O(irq));

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    // Whole run needs about a thousand cycles; this ceiling only cuts a hang
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t read %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t pin %h expected %h", $time, got, exp);
        end
    endtask : chk_pin

    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : settle

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rd_reg

    // Behavioural model: 0 off, 1 power-on reset only, 2 level reset
    function automatic int exp_src(input int m, input int dis, input int ps);
        if (m < 2) return dis ? 1 : 2;
        if (m == 2) return (dis || ps) ? 1 : 2;
        return (dis || ps) ? 0 : 2;
    endfunction : exp_src

    function automatic int exp_op(input logic [7:0] c, input int arm);
        if (!arm) return 0;
        case (c)
            CMD_WRITE_LOW:  return 1;
            CMD_WRITE_HIGH: return 2;
            CMD_ERASE_LOW:  return 4;
            CMD_ERASE_HIGH: return 8;
            default:        return 0;
        endcase
    endfunction : exp_op

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {nrst, wr, rd, b_lvl, b_por, b_det} = '0;
        {addr, wdata, cfg, mode, cyc, fails, checked} = '0;
        void'($urandom(32'h017487db));
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        settle(2);
        rd_reg(REG_AUX_TWO, d);
        chk_reg(d, 8'h00);
        rd_reg(REG_AUX_ONE, d);
        chk_reg(d, 8'h00);
        rd_reg(8'h55, d);
        chk_reg(d, 8'h00);
        // Every command code, one random other value, and a valid code while disarmed
        do code = 8'($urandom); while (exp_op(code, 1) != 0);
        codes = '{CMD_WRITE_LOW, CMD_WRITE_HIGH, CMD_ERASE_LOW, CMD_ERASE_HIGH, code,
                  CMD_ERASE_LOW};
        for (int i = 0; i < 6; i++) begin
            wr_reg(REG_SW_COMMAND, (i < 5) ? CMD_ARM : 8'h00);
            wr_reg(REG_SELFWRITE, codes[i]);
            e = exp_op(codes[i], i < 5);
            chk_pin({7'h0, armed}, {7'h0, i < 5});
            chk_pin({4'h0, e_hi, e_lo, w_hi, w_lo}, 8'(e));
            rd_reg(REG_SELFWRITE, d);
            chk_reg(d, (e != 0) ? 8'h80 : 8'h00);
            wr_reg(REG_SELFWRITE, 8'h00);
        end
        // Undervolt source over every mode, disable and power-save setting
        for (int m = 0; m < 5; m++) begin
            for (int dis = 0; dis < 2; dis++) begin
                for (int ps = 0; ps < 2; ps++) begin
                    @(posedge clk);
                    cfg  <= 8'($urandom);
                    mode <= 3'(m);
                    wr_reg(REG_AUX_TWO, {2'h0, 1'(ps), 5'h0});
                    wr_reg(REG_AUX_ONE, {4'h0, 1'(dis), 3'h0});
                    e = exp_src(m, dis, ps);
                    settle(2);
                    chk_pin({6'h0, src}, 8'(e));
                    chk_pin({5'h0, lvl}, {5'h0, cfg[5:3]});
                    @(posedge clk);
                    b_lvl <= 1'b1;
                    settle(5);
                    chk_pin({7'h0, rreq}, {7'h0, e == 2});
                    @(posedge clk);
                    b_lvl <= 1'b0;
                    b_por <= 1'b1;
                    settle(5);
                    chk_pin({7'h0, rreq}, {7'h0, e == 1});
                    @(posedge clk);
                    b_por <= 1'b0;
                    settle(5);
                    chk_pin({7'h0, rreq}, 8'h00);
                end
            end
        end
        code = 8'($urandom);
        wr_reg(REG_DETECT_SEL, code);
        rd_reg(REG_DETECT_SEL, d);
        chk_reg(d & 8'h0F, code & 8'h0F);
        chk_pin({4'h0, dsel}, {4'h0, code[3:0]});
        rd_reg(REG_IRQ_STATUS, d);
        chk_reg(d, 8'h02);
        wr_reg(REG_IRQ_STATUS, 8'h07);
        // Detect comparator: level readback, rising-edge interrupt, write-one-to-clear
        @(posedge clk);
        b_det <= 1'b1;
        wr_reg(REG_IRQ_MASK, 8'h04);
        settle(2);
        chk_pin({7'h0, irq}, 8'h01);
        rd_reg(REG_DETECT_SEL, d);
        chk_reg(d, {4'h4, code[3:0]});
        rd_reg(REG_IRQ_STATUS, d);
        chk_reg(d, 8'h04);
        @(posedge clk);
        b_det <= 1'b0;
        wr_reg(REG_IRQ_STATUS, 8'h04);
        chk_pin({7'h0, irq}, 8'h00);
        // Reset in mid-run returns the registers to their reset values
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        settle(2);
        rd_reg(REG_AUX_ONE, d);
        chk_reg(d, 8'h00);
        rd_reg(REG_DETECT_SEL, d);
        chk_reg(d, 8'h00);
        // Watchdog: every select code, time-out flag set and cleared
        for (int sel = 0; sel < 4; sel++) begin
            per = (sel == 1) ? 20 : (sel == 2) ? 40 : 80;
            wr_reg(REG_AUX_TWO, {5'h0, 2'(sel), 1'b0});
            wr_reg(REG_SW_COMMAND, CMD_ARM);
            wr_reg(REG_SELFWRITE, CMD_ERASE_HIGH);
            n = 0;
            while (n < 120 && abort !== 1'b1) begin
                settle(1);
                n++;
            end
            if (sel == 0) begin
                chk_pin(8'(n), 8'd120);
            end else begin
                chk_pin({7'h0, n >= per - 3 && n <= per + 3}, 8'h01);
            end
            settle(1);
            rd_reg(REG_SELFWRITE, d);
            chk_reg(d, (sel != 0) ? 8'hC0 : 8'h80);
            rd_reg(REG_IRQ_STATUS, d);
            chk_reg(d, 8'((sel != 0) ? 1 : 0));
            if (sel == 3) begin
                wr_reg(REG_IRQ_MASK, 8'h07);
                irq_a = irq;
                wr_reg(REG_IRQ_MASK, 8'h00);
                chk_pin({7'h0, irq ^ irq_a}, 8'h01);
            end
            wr_reg(REG_SELFWRITE, 8'h00);
            rd_reg(REG_SELFWRITE, d);
            chk_reg(d, 8'h00);
            wr_reg(REG_IRQ_STATUS, 8'h01);
            rd_reg(REG_IRQ_STATUS, d);
            chk_reg(d, 8'h00);
        end
        print_verdict();
    end
endmodule : fsg_guard_tb
